// [dv/scd_board.sv]
// board strap model: open straps float up
// assumes the bench picks levels and driven straps
`timescale 1ns/1ns
`default_nettype none
module scd_board (
  input wire logic [19:0] val_i,
  input wire logic [19:0] drv_i,
  output logic [19:0] strap_o
);
  assign strap_o = val_i & drv_i | ~drv_i;
endmodule // scd_board
`default_nettype wire

// [dv/scd_strap_decoder_test.sv]
// random strap captures against the decoder
// assumes the board model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module scd_strap_decoder_test;
  import scd_pkg::*;
  logic clk_i = 0, rst_n_i = 0, plat = 0, dbg = 0, pm = 0, den, pso, vld;
  logic [19:0] val = '1, drv = '1, strap;
  scd_cfg_t cfg, c;
  int err_total = 0, checks = 0, seed = 32'hA2EE, i, k;
  always #10 clk_i = ~clk_i;
  scd_board brd_u (.val_i(val), .drv_i(drv), .strap_o(strap));
  scd_strap_decoder dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .platform_rst_n_i(plat),
    .strap_i(strap), .strap_driven_i(drv), .debug_optin_bit0_i(dbg),
    .power_state_sideband_i(pm), .cfg_o(cfg), .debug_enable_o(den),
    .power_state_o(pso), .cfg_valid_o(vld));
  function automatic scd_cfg_t exp_cfg(logic [19:0] v, d);
    logic [19:0] e;
    e = v | ~d;
    return '{!e[2], !e[3], e[6:5] == 2'h0 ? SCD_BIF_SPLIT_X8_2X4 :
      e[6:5] == 2'h2 ? SCD_BIF_SPLIT_2X8 : SCD_BIF_SPLIT_BAD};
  endfunction
  task automatic chk(string n, logic [4:0] e, logic [4:0] s);
    checks++;
    if (e !== s) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1;
    for (i = 0; i < 40; i++) begin
      val = $random(seed);
      drv = i < 4 ? '1 : i == 4 ? '0 : $random(seed);
      if (i < 4) val[6:5] = i[1:0];
      if (val[6:5] == 2'h1) val[6:5] = 2'h3;
      c = exp_cfg(val, drv);
      @(negedge clk_i) plat = 0;
      repeat (4) @(negedge clk_i);
      plat = 1;
      for (k = 0; k < 8 && vld !== 1'b1; k++) @(negedge clk_i);
      if (k == 8) begin
        err_total++;
        print_verdict();
      end
      chk("cfg", c, cfg);
      @(negedge clk_i);
      val = $random(seed);
      dbg = $random(seed);
      pm = $random(seed);
      repeat (2) @(negedge clk_i);
      chk("held", c, cfg);
      chk("debug", dbg & !c.debug_optin_forced, den);
      @(negedge clk_i);
      chk("power", pm, pso);
    end
    print_verdict();
  end
endmodule // scd_strap_decoder_test
`default_nettype wire

// [dv/scd_strap_monitor.sv]
// checker for the strap decoder ports
// assumes straps steady while platform reset is low
`timescale 1ns/1ns
`default_nettype none
module scd_strap_monitor
  import scd_pkg::*;
(
  input wire logic clk_i, rst_n_i, platform_rst_n_i, debug_optin_bit0_i,
  input wire logic power_state_sideband_i, debug_enable_o, power_state_o, cfg_valid_o,
  input wire logic [19:0] strap_i, strap_driven_i,
  input wire scd_cfg_t cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [19:0] e = strap_i | ~strap_driven_i;
  wire [2:0] b = e[6:5] == 2'h0 ? 3'h1 : e[6:5] == 2'h2 ? 3'h2 : 3'h4;
  cfg_hold_a: assert property (cfg_valid_o && $past(cfg_valid_o) |-> $stable(cfg_o))
    else $error("cfg moved");
  valid_rise_a: assert property ($rose(platform_rst_n_i) |-> ##[2:4] cfg_valid_o)
    else $error("valid late");
  lane_rev_a: assert property ($rose(cfg_valid_o) |-> cfg_o.lane_reversed == !e[2])
    else $error("lane order");
  open_strap_a: assert property ($rose(cfg_valid_o) && !strap_driven_i[3] |->
    !cfg_o.debug_optin_forced) else $error("open strap");
  dbg_force_a: assert property ($rose(cfg_valid_o) |-> cfg_o.debug_optin_forced == !e[3])
    else $error("override");
  bif_mode_a: assert property ($rose(cfg_valid_o) |-> cfg_o.bifurcation == b)
    else $error("split");
  dbg_en_a: assert property (cfg_valid_o && $past(cfg_valid_o) |-> debug_enable_o ==
    ($past(debug_optin_bit0_i) && !cfg_o.debug_optin_forced)) else $error("debug");
  pm_lag_a: assert property (power_state_o == $past(power_state_sideband_i, 3))
    else $error("sideband");
  cover property ($rose(cfg_valid_o));
  cover property (cfg_valid_o && cfg_o.bifurcation == SCD_BIF_SPLIT_BAD);
  cover property (debug_enable_o);
endmodule // scd_strap_monitor
bind scd_strap_decoder scd_strap_monitor mon_u (.*);
`default_nettype wire

// [hdl/scd_map.svh]
// strap map constants for the strap configuration decoder
// assumes inclusion by the package and the decoder module only
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

`define SCD_STRAP_W 20
`define SCD_BIT_LANE_REV 2
`define SCD_BIT_DBG_PRIV 3
`define SCD_BIF_LO 5
`define SCD_BIF_HI 6
`define SCD_BIF_X8_2X4 2'h0
`define SCD_BIF_RSVD 2'h1
`define SCD_BIF_2X8 2'h2
`define SCD_STRAP_RST 20'hFFFFF
`define SCD_DRIVEN_RST 20'h00000
`define SCD_SYNC_RST 2'h0

`endif

// [hdl/scd_pkg.sv]
// types for the strap configuration decoder
// assumes scd_map.svh sits beside it
`include "scd_map.svh"
package scd_pkg;

  typedef enum logic [2:0] {
    SCD_BIF_SPLIT_X8_2X4 = 3'h1,
    SCD_BIF_SPLIT_2X8    = 3'h2,
    SCD_BIF_SPLIT_BAD    = 3'h4
  } scd_bif_t;

  typedef enum logic [1:0] {
    SCD_ST_CAPTURE = 2'h1,
    SCD_ST_HOLD    = 2'h2
  } scd_state_t;

  typedef struct packed {
    logic lane_reversed;
    logic debug_optin_forced;
    scd_bif_t bifurcation;
  } scd_cfg_t;

endpackage

// [hdl/scd_strap_decoder.sv]
// strap decoder: samples board straps during platform reset, holds decoded settings
// assumes straps and the sideband come from pins outside the clk_i domain
//
// Notes on behaviour
// - an unterminated strap reads as one.
// - lane-reversal strap high keeps normal numbering, low reverses x16 lanes.
// - privacy strap high follows debug opt-in bit 0, low overrides default.
// - bifurcation 00 one x8 two x4, 10 two x8, 01 reserved.
// - reserved strap bits have no configuration effect.
// - the platform sideband status is received on its input.
`timescale 1ns/1ns
`default_nettype none
`include "scd_map.svh"

module scd_strap_decoder
  import scd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // platform reset and board straps
  input wire logic platform_rst_n_i,
  input wire logic [`SCD_STRAP_W-1:0] strap_i,
  input wire logic [`SCD_STRAP_W-1:0] strap_driven_i,
  // debug opt-in register bit 0
  input wire logic debug_optin_bit0_i,
  // power-management sideband
  input wire logic power_state_sideband_i,
  // decoded settings
  output scd_cfg_t cfg_o,
  output logic debug_enable_o,
  output logic power_state_o,
  output logic cfg_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  logic [`SCD_STRAP_W-1:0] strap_s1;
  logic [`SCD_STRAP_W-1:0] strap_s2;
  logic [`SCD_STRAP_W-1:0] driven_s1;
  logic [`SCD_STRAP_W-1:0] driven_s2;
  logic prst_s1;
  logic prst_s2;
  logic pm_s1;
  logic pm_s2;
  logic [`SCD_STRAP_W-1:0] eff_strap;

  // undriven straps float to one; both pins are synchronised before the mux
  genvar g;
  generate
    for (g = 0; g < `SCD_STRAP_W; g++) begin : g_term
      assign eff_strap[g] = driven_s2[g] ? strap_s2[g] : 1'b1;
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_s1 <= `SCD_STRAP_RST;
      strap_s2 <= `SCD_STRAP_RST;
      driven_s1 <= `SCD_DRIVEN_RST;
      driven_s2 <= `SCD_DRIVEN_RST;
      prst_s1 <= 1'b0;
      prst_s2 <= 1'b0;
      pm_s1 <= 1'b0;
      pm_s2 <= 1'b0;
    end else begin
      strap_s1 <= strap_i;
      strap_s2 <= strap_s1;
      driven_s1 <= strap_driven_i;
      driven_s2 <= driven_s1;
      prst_s1 <= platform_rst_n_i;
      prst_s2 <= prst_s1;
      pm_s1 <= power_state_sideband_i;
      pm_s2 <= pm_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic scd_bif_t scd_decode_bif(input logic [1:0] code);
    case (code)
      `SCD_BIF_X8_2X4: scd_decode_bif = SCD_BIF_SPLIT_X8_2X4;
      `SCD_BIF_2X8: scd_decode_bif = SCD_BIF_SPLIT_2X8;
      default: scd_decode_bif = SCD_BIF_SPLIT_BAD;
    endcase
  endfunction

  // only bits 2, 3, 6:5 are read; the rest are ignored
  wire logic lane_rev_w = ~eff_strap[`SCD_BIT_LANE_REV];
  wire logic dbg_force_w = ~eff_strap[`SCD_BIT_DBG_PRIV];
  wire scd_bif_t bif_w = scd_decode_bif(eff_strap[`SCD_BIF_HI:`SCD_BIF_LO]);
  // override leaves debug disabled rather than trusting the default
  wire logic dbg_en_w = cfg_o.debug_optin_forced ? 1'b0 : debug_optin_bit0_i;

  ////////////////////////////////////////////////////////////////////////////
  // capture while platform reset is low, then hold
  scd_state_t state;
  scd_state_t next_state;

  always_comb begin
    case (state)
      SCD_ST_CAPTURE: next_state = prst_s2 ? SCD_ST_HOLD : SCD_ST_CAPTURE;
      SCD_ST_HOLD: next_state = prst_s2 ? SCD_ST_HOLD : SCD_ST_CAPTURE;
      default: next_state = SCD_ST_CAPTURE;
    endcase
  end

  wire logic capture_w = (state == SCD_ST_CAPTURE) && !prst_s2;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SCD_ST_CAPTURE;
      cfg_o <= '{lane_reversed: 1'b0, debug_optin_forced: 1'b0,
                 bifurcation: SCD_BIF_SPLIT_BAD};
      cfg_valid_o <= 1'b0;
      debug_enable_o <= 1'b0;
      power_state_o <= 1'b0;
    end else begin
      state <= next_state;
      if (capture_w) begin
        cfg_o <= '{lane_reversed: lane_rev_w, debug_optin_forced: dbg_force_w,
                   bifurcation: bif_w};
      end
      cfg_valid_o <= (next_state == SCD_ST_HOLD);
      debug_enable_o <= dbg_en_w;
      power_state_o <= pm_s2;
    end
  end

endmodule // scd_strap_decoder
`default_nettype wire
